// file: design/pld_cfg_reg.sv
// One byte-wide configuration register with implemented-bit mask
`timescale 1ns/10ps
module pld_cfg_reg #(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] BIT_MASK = 8'hff
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Write side
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    // Stored value
    output logic [7:0] value_q
);

    // Unimplemented bits never store and read as zero
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            value_q <= RESET_VAL & BIT_MASK;
        end else if (wr_en) begin
            value_q <= wr_data & BIT_MASK;
        end
    end

endmodule // pld_cfg_reg

// file: design/pld_loop_divider_config.sv
// Loop divider configuration registers: pump mode, loop mode, divider counts
//
// Behaviour
// R1: Pump mode field selects hiz/source/sink/normal.
// R2: Loop mode: run, async/sync power-down, unused.
// R3: Reference count low byte at 0x011, reset 0x01.
// R4: Reference count upper six bits at 0x012.
// R5: Six-bit swallow count at 0x013, reset zero.
// R6: Feedback count low byte at 0x014.
// R7: Feedback count upper five bits at 0x015.
// R8: Bit 7 of pump_pin_control forces pump pin mid-supply.
// R9: Join byte halves; unused bits read zero.
`timescale 1ns/10ps
module pld_loop_divider_config
    import pld_pkg::*;
#(
    parameter int REG_ADDR_W = pld_pkg::ADDR_W
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register port from the serial control port decoder
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [pld_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [pld_pkg::DATA_W-1:0] reg_wdata,
    output logic [pld_pkg::DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    // Charge pump controls
    output pld_pkg::pld_drive_t pump_drive_select,
    output logic pump_hiz,
    output logic pump_force_source,
    output logic pump_force_sink,
    output logic pump_output_pin_midsupply,
    // Loop mode controls
    output pld_pkg::pld_loop_t loop_mode,
    output logic loop_enable,
    output logic loop_async_powerdown,
    output logic loop_sync_powerdown,
    // Divider counts
    output logic [pld_pkg::REF_W-1:0] ref_divider_count,
    output logic [pld_pkg::SWALLOW_W-1:0] swallow_count,
    output logic [pld_pkg::FB_W-1:0] feedback_count
);

    import pld_pkg::*;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    generate
        if (REG_ADDR_W != ADDR_W) begin : g_bad_addr_w
            $error("pld_loop_divider_config: address width must match the package");
        end
        if (NREG > (1 << IDX_W)) begin : g_bad_nreg
            $error("pld_loop_divider_config: register count exceeds the index width");
        end
        if ((REF_W <= DATA_W) || (REF_W > 2 * DATA_W)) begin : g_bad_ref_w
            $error("pld_loop_divider_config: reference count must span two bytes");
        end
        if ((FB_W <= DATA_W) || (FB_W > 2 * DATA_W)) begin : g_bad_fb_w
            $error("pld_loop_divider_config: feedback count must span two bytes");
        end
        if (SWALLOW_W > DATA_W) begin : g_bad_swallow_w
            $error("pld_loop_divider_config: swallow count must fit one byte");
        end
        if (MID_BIT >= DATA_W) begin : g_bad_mid_bit
            $error("pld_loop_divider_config: mid-supply bit outside the register");
        end
        if ((DRV_LSB + $bits(pld_drive_t) > DATA_W) || (LOOP_LSB + $bits(pld_loop_t) > DATA_W)) begin : g_bad_mode
            $error("pld_loop_divider_config: mode field outside the register");
        end
    endgenerate

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Returns {hit, index}
    function automatic logic [IDX_W:0] pld_decode(input logic [ADDR_W-1:0] addr);
        if (addr == OFS_PUMP_AND_LOOP_MODE) begin
            pld_decode = {1'b1, IDX_MODE};
        end else if (addr == OFS_REF_DIVIDER_LOW) begin
            pld_decode = {1'b1, IDX_REF_LO}; // [R3]
        end else if (addr == OFS_REF_DIVIDER_HIGH) begin
            pld_decode = {1'b1, IDX_REF_HI}; // [R4]
        end else if (addr == OFS_SWALLOW_COUNT) begin
            pld_decode = {1'b1, IDX_SWALLOW}; // [R5]
        end else if (addr == OFS_FEEDBACK_COUNT_LOW) begin
            pld_decode = {1'b1, IDX_FB_LO}; // [R6]
        end else if (addr == OFS_FEEDBACK_COUNT_HIGH) begin
            pld_decode = {1'b1, IDX_FB_HI}; // [R7]
        end else if (addr == OFS_PUMP_PIN_CONTROL) begin
            pld_decode = {1'b1, IDX_PUMP}; // [R8]
        end else begin
            pld_decode = {1'b0, IDX_MODE};
        end
    endfunction

    logic [IDX_W:0] wr_sel;
    logic [IDX_W:0] rd_sel;

    assign wr_sel = pld_decode(reg_addr);
    assign rd_sel = pld_decode(reg_addr);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [DATA_W-1:0] reg_q [NREG];

    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++) begin : g_reg
            localparam logic [IDX_W-1:0] GIDX = IDX_W'(gi);
            // Masks keep unused bits at zero [R9]
            pld_cfg_reg #(
                .RESET_VAL(pld_reset_of(GIDX)),
                .BIT_MASK(pld_mask_of(GIDX))
            ) u_reg (
                .mclk(mclk),
                .rst_n(rst_n),
                .wr_en(reg_wr && wr_sel[IDX_W] && (wr_sel[IDX_W-1:0] == GIDX)),
                .wr_data(reg_wdata),
                .value_q(reg_q[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Unmapped addresses answer zero
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (rd_sel[IDX_W]) begin
                reg_rdata <= reg_q[rd_sel[IDX_W-1:0]]; // [R9]
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
        end
    end

    // ------------------------------------------------------------
    // Mode fields
    // ------------------------------------------------------------
    localparam int MODE_W = $bits(pld_drive_t);

    assign pump_drive_select = pld_drive_t'(reg_q[IDX_MODE][DRV_LSB +: MODE_W]); // [R1]
    assign loop_mode = pld_loop_t'(reg_q[IDX_MODE][LOOP_LSB +: MODE_W]); // [R2]

    // ------------------------------------------------------------
    // Decoded pump and loop flags
    // ------------------------------------------------------------
    // Flags leave reset agreeing with the reset mode register
    localparam pld_drive_t DRV_RST = pld_drive_t'(RST_MODE[DRV_LSB +: MODE_W]);
    localparam pld_loop_t LOOP_RST = pld_loop_t'(RST_MODE[LOOP_LSB +: MODE_W]);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pump_hiz <= (DRV_RST == PLD_DRV_HIZ);
        end else begin
            pump_hiz <= (pump_drive_select == PLD_DRV_HIZ); // [R1]
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pump_force_source <= (DRV_RST == PLD_DRV_SOURCE);
        end else begin
            pump_force_source <= (pump_drive_select == PLD_DRV_SOURCE); // [R1]
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pump_force_sink <= (DRV_RST == PLD_DRV_SINK);
        end else begin
            pump_force_sink <= (pump_drive_select == PLD_DRV_SINK); // [R1]
        end
    end

    // Unused loop code holds neither run nor power-down
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            loop_enable <= (LOOP_RST == PLD_LOOP_RUN);
        end else begin
            loop_enable <= (loop_mode == PLD_LOOP_RUN); // [R2]
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            loop_async_powerdown <= (LOOP_RST == PLD_LOOP_ASYNC_PD);
        end else begin
            loop_async_powerdown <= (loop_mode == PLD_LOOP_ASYNC_PD); // [R2]
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            loop_sync_powerdown <= (LOOP_RST == PLD_LOOP_SYNC_PD);
        end else begin
            loop_sync_powerdown <= (loop_mode == PLD_LOOP_SYNC_PD); // [R2]
        end
    end

    // ------------------------------------------------------------
    // Pump pin and divider counts
    // ------------------------------------------------------------
    assign pump_output_pin_midsupply = reg_q[IDX_PUMP][MID_BIT]; // [R8]

    // Reference and feedback counts from their byte halves; swallow count from one byte
    assign ref_divider_count = {reg_q[IDX_REF_HI][REF_W-DATA_W-1:0], reg_q[IDX_REF_LO]}; // [R3] [R4] [R9]
    assign swallow_count = reg_q[IDX_SWALLOW][SWALLOW_W-1:0]; // [R5]
    assign feedback_count = {reg_q[IDX_FB_HI][FB_W-DATA_W-1:0], reg_q[IDX_FB_LO]}; // [R6] [R7] [R9]

endmodule // pld_loop_divider_config

// file: design/pld_pkg.sv
// Constants, field layout and mode encodings for the loop divider configuration slice
package pld_pkg;

    // ------------------------------------------------------------
    // Bus widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    localparam int NREG = 7;
    localparam int IDX_W = 3;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_PUMP_AND_LOOP_MODE = 10'h010;
    localparam logic [ADDR_W-1:0] OFS_REF_DIVIDER_LOW = 10'h011;
    localparam logic [ADDR_W-1:0] OFS_REF_DIVIDER_HIGH = 10'h012;
    localparam logic [ADDR_W-1:0] OFS_SWALLOW_COUNT = 10'h013;
    localparam logic [ADDR_W-1:0] OFS_FEEDBACK_COUNT_LOW = 10'h014;
    localparam logic [ADDR_W-1:0] OFS_FEEDBACK_COUNT_HIGH = 10'h015;
    localparam logic [ADDR_W-1:0] OFS_PUMP_PIN_CONTROL = 10'h016;

    // ------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_MODE = 3'h0;
    localparam logic [IDX_W-1:0] IDX_REF_LO = 3'h1;
    localparam logic [IDX_W-1:0] IDX_REF_HI = 3'h2;
    localparam logic [IDX_W-1:0] IDX_SWALLOW = 3'h3;
    localparam logic [IDX_W-1:0] IDX_FB_LO = 3'h4;
    localparam logic [IDX_W-1:0] IDX_FB_HI = 3'h5;
    localparam logic [IDX_W-1:0] IDX_PUMP = 3'h6;

    // ------------------------------------------------------------
    // Reset values and implemented-bit masks
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] RST_MODE = 8'h0d;
    localparam logic [DATA_W-1:0] RST_REF_LO = 8'h01;
    localparam logic [DATA_W-1:0] RST_REF_HI = 8'h00;
    localparam logic [DATA_W-1:0] RST_SWALLOW = 8'h00;
    localparam logic [DATA_W-1:0] RST_FB_LO = 8'h00;
    localparam logic [DATA_W-1:0] RST_FB_HI = 8'h00;
    localparam logic [DATA_W-1:0] RST_PUMP = 8'h00;

    localparam logic [DATA_W-1:0] MSK_MODE = 8'h0f;
    localparam logic [DATA_W-1:0] MSK_REF_LO = 8'hff;
    localparam logic [DATA_W-1:0] MSK_REF_HI = 8'h3f;
    localparam logic [DATA_W-1:0] MSK_SWALLOW = 8'h3f;
    localparam logic [DATA_W-1:0] MSK_FB_LO = 8'hff;
    localparam logic [DATA_W-1:0] MSK_FB_HI = 8'h1f;
    localparam logic [DATA_W-1:0] MSK_PUMP = 8'h80;

    // ------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------
    localparam int DRV_LSB = 2;
    localparam int LOOP_LSB = 0;
    localparam int MID_BIT = 7;
    localparam int REF_W = 14;
    localparam int SWALLOW_W = 6;
    localparam int FB_W = 13;

    // ------------------------------------------------------------
    // Mode encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PLD_DRV_HIZ = 2'h0,
        PLD_DRV_SOURCE = 2'h1,
        PLD_DRV_SINK = 2'h2,
        PLD_DRV_NORMAL = 2'h3
    } pld_drive_t;

    typedef enum logic [1:0] {
        PLD_LOOP_RUN = 2'h0,
        PLD_LOOP_ASYNC_PD = 2'h1,
        PLD_LOOP_UNUSED = 2'h2,
        PLD_LOOP_SYNC_PD = 2'h3
    } pld_loop_t;

    // ------------------------------------------------------------
    // Per-index tables
    // ------------------------------------------------------------
    function automatic logic [DATA_W-1:0] pld_reset_of(input logic [IDX_W-1:0] idx);
        case (idx)
            IDX_MODE: pld_reset_of = RST_MODE;
            IDX_REF_LO: pld_reset_of = RST_REF_LO;
            IDX_REF_HI: pld_reset_of = RST_REF_HI;
            IDX_SWALLOW: pld_reset_of = RST_SWALLOW;
            IDX_FB_LO: pld_reset_of = RST_FB_LO;
            IDX_FB_HI: pld_reset_of = RST_FB_HI;
            default: pld_reset_of = RST_PUMP;
        endcase
    endfunction

    function automatic logic [DATA_W-1:0] pld_mask_of(input logic [IDX_W-1:0] idx);
        case (idx)
            IDX_MODE: pld_mask_of = MSK_MODE;
            IDX_REF_LO: pld_mask_of = MSK_REF_LO;
            IDX_REF_HI: pld_mask_of = MSK_REF_HI;
            IDX_SWALLOW: pld_mask_of = MSK_SWALLOW;
            IDX_FB_LO: pld_mask_of = MSK_FB_LO;
            IDX_FB_HI: pld_mask_of = MSK_FB_HI;
            default: pld_mask_of = MSK_PUMP;
        endcase
    endfunction

endpackage

// file: verif/pld_loop_divider_config_bench.sv
// Self-checking bench for the loop divider configuration slice
`timescale 1ns/10ps
module pld_loop_divider_config_bench;
    import pld_pkg::*;
    logic mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
    logic [9:0] reg_addr = '0;
    logic [7:0] reg_wdata = '0, reg_rdata;
    logic reg_rvalid, pump_hiz, pump_force_source, pump_force_sink, pump_output_pin_midsupply;
    logic loop_enable, loop_async_powerdown, loop_sync_powerdown;
    pld_drive_t pump_drive_select;
    pld_loop_t loop_mode;
    logic [13:0] ref_divider_count;
    logic [5:0] swallow_count;
    logic [12:0] feedback_count;
    logic [7:0] exp_q[$];
    logic [7:0] mdl [7];
    int errors = 0, checks_done = 0;
    localparam logic [7:0] MASK [7] = '{8'h0f, 8'hff, 8'h3f, 8'h3f, 8'hff, 8'h1f, 8'h80};
    localparam logic [7:0] RSTV [7] = '{8'h0d, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    always #5 mclk = ~mclk;

    pld_loop_divider_config dut_u (.mclk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
        .pump_drive_select, .pump_hiz, .pump_force_source, .pump_force_sink, .pump_output_pin_midsupply,
        .loop_mode, .loop_enable, .loop_async_powerdown, .loop_sync_powerdown, .ref_divider_count,
        .swallow_count, .feedback_count);

    // ------------------------------------------------------------
    // Driving, checking and closing
    // ------------------------------------------------------------
    task automatic chk(input logic [13:0] got, input logic [13:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input logic w, input logic r, input logic [9:0] a, input logic [7:0] d);
        logic mapped;
        mapped = (a[9:3] == 7'h02) && (a[2:0] != 3'h7);
        @(posedge mclk);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        if (r) exp_q.push_back(mapped ? mdl[a[2:0]] : 8'h00);
        if (w && mapped) mdl[a[2:0]] = d & MASK[a[2:0]];
    endtask

    task automatic fields();
        logic [1:0] drv;
        logic [1:0] lp;
        cyc(0, 0, 0, 0);
        cyc(0, 0, 0, 0);
        drv = mdl[0][3:2];
        lp = mdl[0][1:0];
        @(negedge mclk);
        chk(pump_drive_select, drv);
        chk({pump_hiz, pump_force_source, pump_force_sink}, {drv == 2'h0, drv == 2'h1, drv == 2'h2});
        chk(loop_mode, lp);
        chk({loop_enable, loop_async_powerdown, loop_sync_powerdown}, {lp == 2'h0, lp == 2'h1, lp == 2'h3});
        chk(ref_divider_count, {mdl[2][5:0], mdl[1]});
        chk(swallow_count, mdl[3][5:0]);
        chk(feedback_count, {mdl[5][4:0], mdl[4]});
        chk(pump_output_pin_midsupply, mdl[6][7]);
    endtask

    task automatic rdall();
        for (int i = 0; i < 8; i++) cyc(0, 1, 10'h010 + 10'(i), 0);
        cyc(0, 1, 10'h3ff, 0);
        cyc(0, 0, 0, 0);
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge mclk) begin
        if (rst_n && reg_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                errors++;
                $display("ERROR %0t: unexpected read data", $time);
            end else chk(reg_rdata, exp_q.pop_front());
        end
    end

    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        $display("ERROR %0t: timeout", $time);
        end_of_test();
    end

    initial begin
        void'($urandom(81624));
        mdl = RSTV;
        repeat (3) @(posedge mclk);
        rst_n <= 1;
        fields();
        rdall();
        for (int i = 0; i < 16; i++) begin
            cyc(1, 0, 10'h010, {4'($urandom), 4'(i)});
            fields();
            cyc(0, 1, 10'h010, 0);
        end
        for (int n = 0; n < 200; n++) begin
            cyc(1, 1'($urandom), (n % 5 == 4) ? {2'h1, 8'($urandom)} : {7'h02, 3'($urandom)}, 8'($urandom));
            if (n % 20 == 19) begin
                fields();
                rdall();
            end
        end
        @(posedge mclk);
        rst_n <= 0;
        repeat (3) @(posedge mclk);
        rst_n <= 1;
        mdl = RSTV;
        exp_q.delete();
        fields();
        rdall();
        for (int k = 0; k < 10 && exp_q.size() > 0; k++) @(posedge mclk);
        if (exp_q.size() > 0) begin
            errors++;
            $display("ERROR %0t: reads left unanswered", $time);
        end
        end_of_test();
    end
endmodule // pld_loop_divider_config_bench

// file: verif/pld_loop_divider_config_chk.sv
// Port checker for the loop divider configuration slice
`timescale 1ns/10ps
module pld_loop_divider_config_chk
    import pld_pkg::*;
(
    input wire logic mclk, rst_n, reg_wr, reg_rd,
    input wire logic [9:0] reg_addr,
    input wire logic [7:0] reg_wdata, reg_rdata,
    input wire logic reg_rvalid, pump_hiz, pump_force_source, pump_force_sink, pump_output_pin_midsupply,
    input pld_pkg::pld_drive_t pump_drive_select,
    input pld_pkg::pld_loop_t loop_mode,
    input wire logic loop_enable, loop_async_powerdown, loop_sync_powerdown,
    input wire logic [13:0] ref_divider_count,
    input wire logic [5:0] swallow_count,
    input wire logic [12:0] feedback_count
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // Register port and fields
    // ------------------------------------------------------------
    read_valid_a: assert property (reg_rd |=> reg_rvalid) else $error("read valid missing");
    unmapped_zero_a: assert property (reg_rd && (reg_addr < 10'h010 || reg_addr > 10'h016)
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    drive_decode_a: assert property (1 |=> pump_hiz == ($past(pump_drive_select) == PLD_DRV_HIZ)
        && pump_force_source == ($past(pump_drive_select) == PLD_DRV_SOURCE)
        && pump_force_sink == ($past(pump_drive_select) == PLD_DRV_SINK)) else $error("pump decode wrong");
    loop_decode_a: assert property (1 |=> loop_enable == ($past(loop_mode) == PLD_LOOP_RUN)
        && loop_async_powerdown == ($past(loop_mode) == PLD_LOOP_ASYNC_PD)
        && loop_sync_powerdown == ($past(loop_mode) == PLD_LOOP_SYNC_PD)) else $error("loop decode wrong");
    ref_low_a: assert property (reg_wr && reg_addr == 10'h011 |=> ref_divider_count[7:0] == $past(reg_wdata))
        else $error("ref low wrong");
    ref_high_a: assert property (reg_wr && reg_addr == 10'h012 |=> {2'h0, ref_divider_count[13:8]} ==
        ($past(reg_wdata) & 8'h3f)) else $error("ref high wrong");
    swallow_wr_a: assert property (reg_wr && reg_addr == 10'h013 |=> {2'h0, swallow_count} ==
        ($past(reg_wdata) & 8'h3f)) else $error("swallow wrong");
    fb_low_a: assert property (reg_wr && reg_addr == 10'h014 |=> feedback_count[7:0] == $past(reg_wdata))
        else $error("feedback low wrong");
    fb_high_a: assert property (reg_wr && reg_addr == 10'h015 |=> {3'h0, feedback_count[12:8]} ==
        ($past(reg_wdata) & 8'h1f)) else $error("feedback high wrong");
    pump_mid_a: assert property (reg_wr && reg_addr == 10'h016 |=> {pump_output_pin_midsupply, 7'h00} ==
        ($past(reg_wdata) & 8'h80)) else $error("mid supply wrong");
    count_hold_a: assert property (!reg_wr |=> $stable(ref_divider_count) && $stable(swallow_count)
        && $stable(feedback_count)) else $error("count changed without write");
    cover property (reg_wr && reg_rd);
    cover property (reg_rd && reg_addr == 10'h017);
    cover property (reg_wr && reg_addr == 10'h010 ##1 reg_rd);
endmodule // pld_loop_divider_config_chk
bind pld_loop_divider_config pld_loop_divider_config_chk chk_u (.mclk, .rst_n, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_rvalid, .pump_hiz, .pump_force_source, .pump_force_sink, .pump_output_pin_midsupply,
    .pump_drive_select, .loop_mode, .loop_enable, .loop_async_powerdown, .loop_sync_powerdown, .ref_divider_count,
    .swallow_count, .feedback_count);
